// >>> common/gx_consts.svh
// Constants of the gateway exchange map: addresses, codes and limits.
`ifndef GX_CONSTS_SVH
`define GX_CONSTS_SVH

// Process data per direction and the derived word count.
`define GX_MAX_BYTES 480
`define GX_DEPTH (`GX_MAX_BYTES / 2)
`define GX_MAX_WORDS 8'(`GX_MAX_BYTES / 2)

// Word addresses as numbered by the master (first address of each range).
`define GX_RX_BASE 16'h0001
`define GX_TX_BASE 16'h0401
`define GX_LINK_ADDR 16'h1001
`define GX_BUS_ADDR 16'h1002
`define GX_ARX_BASE 16'h7531
`define GX_ATX_BASE 16'h9C41

// Coil addresses, sixteen coils to one word.
`define GX_CRX_BASE 16'h0001
`define GX_CTX_BASE 16'h4001

// Function codes.
`define GX_FC_RD_COILS 8'h01
`define GX_FC_RD_DINS 8'h02
`define GX_FC_RD_HOLD 8'h03
`define GX_FC_RD_INPUT 8'h04
`define GX_FC_WR_COIL 8'h05
`define GX_FC_WR_REG 8'h06
`define GX_FC_WR_COILS 8'h0F
`define GX_FC_WR_REGS 8'h10
`define GX_FC_MASK_WR 8'h16
`define GX_FC_RDWR 8'h17

// Exception codes.
`define GX_EXC_NONE 8'h00
`define GX_EXC_FUNC 8'h01
`define GX_EXC_ADDR 8'h02

// Object class codes.
`define GX_OBJ_IDENT 8'h01
`define GX_OBJ_ROUTER 8'h02
`define GX_OBJ_ASSY 8'h04
`define GX_OBJ_CONN 8'h06
`define GX_OBJ_TCPIP 8'hF5
`define GX_OBJ_LINK 8'hF6
`define GX_OBJ_RING 8'h47
`define GX_OBJ_QOS 8'h48
`define GX_OBJ_IN_DATA 8'hA0
`define GX_OBJ_OUT_DATA 8'hA1

// Reset values.
`define GX_STATE_RST 16'h0000
`define GX_WORD_RST 16'h0000

`endif

// >>> common/gx_pkg.sv
// Types shared by the gateway exchange map.
package gx_pkg;

  typedef enum logic [1:0] {
    GX_RGN_NONE,
    GX_RGN_RX,
    GX_RGN_TX,
    GX_RGN_STAT
  } gx_region_t;

  typedef struct packed {
    gx_region_t rgn;
    logic [7:0] idx;
    logic [3:0] bit_no;
  } gx_loc_t;

endpackage : gx_pkg

// >>> src/gx_sync3.sv
// Three-stage input synchroniser that accepts a value once stable.
`timescale 1ns/1ps
module gx_sync3 #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Asynchronous input and its settled copy
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire agree = (s2 == s3);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      o_sync <= '0;
    end else begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
      if (agree) begin
        o_sync <= s3;
      end
    end
  end

endmodule : gx_sync3

// >>> src/gx_exchange_map.sv
// Master-facing register, coil and object map of the exchange buffers.
`timescale 1ns/1ps
`include "gx_consts.svh"

// What this block does
// - Word and bit read, write, masked write and read/write codes work.
// - Words 1 to 240 show, read only, what the partner half delivered.
// - Words 1025 to 1264 hold what the master writes for the partner.
// - Alias word ranges reach exactly the same cells as the main ranges.
// - Word 4097 reports the progress of the partner link.
// - Word 4098 reports the state of the other fieldbus.
// - Coils reach the word storage itself, not a memory of their own.
// - Each group of sixteen coils maps onto the bits of one word.
// - Coils 1 to 3840 are read only and writes leave them unchanged.
// - Coils 16385 to 20224 may be read and written.
// - The input-data object reads the words sent to the master.
// - The output-data object writes the words sent to the partner.
// - The standard object classes are accepted at their class codes.
// - Data per direction is at most 480 bytes and the shorter bus wins.
module gx_exchange_map
  import gx_pkg::*;
(
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // Master request
  input wire logic I_REQ_VALID,
  input wire logic I_REQ_OBJ,
  input wire logic [7:0] I_REQ_FUNC,
  input wire logic [15:0] I_REQ_ADDR,
  input wire logic [15:0] I_REQ_RD_ADDR,
  input wire logic [15:0] I_REQ_WDATA,
  input wire logic [15:0] I_REQ_AND_MASK,
  input wire logic [15:0] I_REQ_OR_MASK,
  // Answer to the master
  output logic O_RSP_VALID,
  output logic [7:0] O_RSP_EXC,
  output logic O_RSP_STD,
  output logic [15:0] O_RSP_DATA,
  // Partner half
  input wire logic I_PTN_WR_EN,
  input wire logic [7:0] I_PTN_WR_IDX,
  input wire logic [15:0] I_PTN_WR_DATA,
  input wire logic [7:0] I_PTN_RD_IDX,
  output logic [15:0] O_PTN_RD_DATA,
  input wire logic [8:0] I_PTN_MAX_BYTES,
  // Status pins
  input wire logic [15:0] I_LINK_STATE,
  input wire logic [15:0] I_BUS_STATE,
  output logic [7:0] O_EFF_WORDS
);

  logic [15:0] rx_mem [`GX_DEPTH];
  logic [15:0] tx_mem [`GX_DEPTH];
  logic [15:0] link_q;
  logic [15:0] bus_q;
  gx_sync3 #(.W(16)) u_link_sync (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_async(I_LINK_STATE),
    .o_sync(link_q)
  );
  gx_sync3 #(.W(16)) u_bus_sync (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_async(I_BUS_STATE),
    .o_sync(bus_q)
  );
  // Usable words are limited by the shorter of the two buses.
  wire [7:0] ptn_words = I_PTN_MAX_BYTES[8:1];
  wire [7:0] next_eff = (ptn_words > `GX_MAX_WORDS) ? `GX_MAX_WORDS :
                        ptn_words;
  // Maps a word address, main or alias, onto region and cell index.
  function automatic gx_loc_t word_loc(input logic [15:0] a,
                                       input logic [7:0] lim);
    gx_loc_t l;
    logic [15:0] o_rx;
    logic [15:0] o_arx;
    logic [15:0] o_tx;
    logic [15:0] o_atx;
    o_rx = a - `GX_RX_BASE;
    o_arx = a - `GX_ARX_BASE;
    o_tx = a - `GX_TX_BASE;
    o_atx = a - `GX_ATX_BASE;
    l.rgn = GX_RGN_NONE;
    l.idx = 8'h00;
    l.bit_no = 4'h0;
    if (o_rx < {8'h00, lim}) begin
      l.rgn = GX_RGN_RX;
      l.idx = o_rx[7:0];
    end else if (o_arx < {8'h00, lim}) begin
      l.rgn = GX_RGN_RX;
      l.idx = o_arx[7:0];
    end else if (o_tx < {8'h00, lim}) begin
      l.rgn = GX_RGN_TX;
      l.idx = o_tx[7:0];
    end else if (o_atx < {8'h00, lim}) begin
      l.rgn = GX_RGN_TX;
      l.idx = o_atx[7:0];
    end else if (a == `GX_LINK_ADDR) begin
      l.rgn = GX_RGN_STAT;
    end else if (a == `GX_BUS_ADDR) begin
      l.rgn = GX_RGN_STAT;
      l.idx = 8'h01;
    end
    return l;
  endfunction : word_loc
  // Maps a coil address onto the word and bit that carry it.
  function automatic gx_loc_t coil_loc(input logic [15:0] a,
                                       input logic [7:0] lim);
    gx_loc_t l;
    logic [15:0] o_rx;
    logic [15:0] o_tx;
    o_rx = a - `GX_CRX_BASE;
    o_tx = a - `GX_CTX_BASE;
    l.rgn = GX_RGN_NONE;
    l.idx = 8'h00;
    l.bit_no = 4'h0;
    if ({4'h0, o_rx[15:4]} < {8'h00, lim}) begin
      l.rgn = GX_RGN_RX;
      l.idx = o_rx[11:4];
      l.bit_no = o_rx[3:0];
    end else if ({4'h0, o_tx[15:4]} < {8'h00, lim}) begin
      l.rgn = GX_RGN_TX;
      l.idx = o_tx[11:4];
      l.bit_no = o_tx[3:0];
    end
    return l;
  endfunction : coil_loc
  wire gx_loc_t wloc = word_loc(I_REQ_ADDR, O_EFF_WORDS);
  wire gx_loc_t rloc = word_loc(I_REQ_RD_ADDR, O_EFF_WORDS);
  wire gx_loc_t cloc = coil_loc(I_REQ_ADDR, O_EFF_WORDS);
  wire obj_hit = (I_REQ_ADDR < {8'h00, O_EFF_WORDS});
  wire [7:0] obj_idx = I_REQ_ADDR[7:0];
  wire [15:0] stat_word = wloc.idx[0] ? bus_q : link_q;
  wire [15:0] wsel_word = (wloc.rgn == GX_RGN_RX) ? rx_mem[wloc.idx] :
                          (wloc.rgn == GX_RGN_TX) ? tx_mem[wloc.idx] :
                          (wloc.rgn == GX_RGN_STAT) ? stat_word :
                          16'h0000;
  wire [15:0] rstat_word = rloc.idx[0] ? bus_q : link_q;
  wire [15:0] rsel_word = (rloc.rgn == GX_RGN_RX) ? rx_mem[rloc.idx] :
                          (rloc.rgn == GX_RGN_TX) ? tx_mem[rloc.idx] :
                          (rloc.rgn == GX_RGN_STAT) ? rstat_word :
                          16'h0000;
  // Coils read the word storage itself.
  wire [15:0] coil_word = (cloc.rgn == GX_RGN_RX) ? rx_mem[cloc.idx] :
                          tx_mem[cloc.idx];
  wire coil_bit = coil_word[cloc.bit_no];
  wire [15:0] coil_sel = 16'h0001 << cloc.bit_no;
  wire [15:0] coil_new = (coil_word & ~coil_sel) |
                         (I_REQ_WDATA[0] ? coil_sel : 16'h0000);
  wire [15:0] mask_new = (wsel_word & I_REQ_AND_MASK) |
                         (I_REQ_OR_MASK & ~I_REQ_AND_MASK);
  wire rdwr_same = (rloc.rgn == GX_RGN_TX) && (rloc.idx == wloc.idx);
  wire is_std_obj = (I_REQ_FUNC == `GX_OBJ_IDENT) ||
                    (I_REQ_FUNC == `GX_OBJ_ROUTER) ||
                    (I_REQ_FUNC == `GX_OBJ_ASSY) ||
                    (I_REQ_FUNC == `GX_OBJ_CONN) ||
                    (I_REQ_FUNC == `GX_OBJ_TCPIP) ||
                    (I_REQ_FUNC == `GX_OBJ_LINK) ||
                    (I_REQ_FUNC == `GX_OBJ_RING) ||
                    (I_REQ_FUNC == `GX_OBJ_QOS);
  logic [7:0] next_exc;
  logic [15:0] next_data;
  logic next_std;
  logic wr_en;
  logic [7:0] wr_idx;
  logic [15:0] wr_val;
  always_comb begin
    next_exc = `GX_EXC_NONE;
    next_data = 16'h0000;
    next_std = 1'b0;
    wr_en = 1'b0;
    wr_idx = wloc.idx;
    wr_val = I_REQ_WDATA;
    if (I_REQ_OBJ) begin
      case (I_REQ_FUNC)
        `GX_OBJ_IN_DATA: begin
          if (obj_hit) begin
            next_data = rx_mem[obj_idx];
          end else begin
            next_exc = `GX_EXC_ADDR;
          end
        end
        `GX_OBJ_OUT_DATA: begin
          if (obj_hit) begin
            wr_en = 1'b1;
            wr_idx = obj_idx;
          end else begin
            next_exc = `GX_EXC_ADDR;
          end
        end
        default: begin
          if (is_std_obj) begin
            next_std = 1'b1;
          end else begin
            next_exc = `GX_EXC_FUNC;
          end
        end
      endcase
    end else begin
      case (I_REQ_FUNC)
        `GX_FC_RD_COILS, `GX_FC_RD_DINS: begin
          if (cloc.rgn == GX_RGN_NONE) begin
            next_exc = `GX_EXC_ADDR;
          end else begin
            next_data = {15'h0000, coil_bit};
          end
        end
        `GX_FC_WR_COIL, `GX_FC_WR_COILS: begin
          if (cloc.rgn == GX_RGN_TX) begin
            wr_en = 1'b1;
            wr_idx = cloc.idx;
            wr_val = coil_new;
          end else begin
            next_exc = `GX_EXC_ADDR;
          end
        end
        `GX_FC_RD_HOLD, `GX_FC_RD_INPUT: begin
          if (wloc.rgn == GX_RGN_NONE) begin
            next_exc = `GX_EXC_ADDR;
          end else begin
            next_data = wsel_word;
          end
        end
        `GX_FC_WR_REG, `GX_FC_WR_REGS: begin
          if (wloc.rgn == GX_RGN_TX) begin
            wr_en = 1'b1;
          end else begin
            next_exc = `GX_EXC_ADDR;
          end
        end
        `GX_FC_MASK_WR: begin
          if (wloc.rgn == GX_RGN_TX) begin
            wr_en = 1'b1;
            wr_val = mask_new;
            next_data = mask_new;
          end else begin
            next_exc = `GX_EXC_ADDR;
          end
        end
        `GX_FC_RDWR: begin
          if ((wloc.rgn == GX_RGN_TX) && (rloc.rgn != GX_RGN_NONE)) begin
            wr_en = 1'b1;
            next_data = rdwr_same ? I_REQ_WDATA : rsel_word;
          end else begin
            next_exc = `GX_EXC_ADDR;
          end
        end
        default: begin
          next_exc = `GX_EXC_FUNC;
        end
      endcase
    end
  end

  wire master_wr = I_REQ_VALID && wr_en;
  wire ptn_wr = I_PTN_WR_EN && (I_PTN_WR_IDX < `GX_MAX_WORDS);
  wire [15:0] ptn_rd = (I_PTN_RD_IDX < `GX_MAX_WORDS) ?
                       tx_mem[I_PTN_RD_IDX] : 16'h0000;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      for (int i = 0; i < `GX_DEPTH; i++) begin
        rx_mem[i] <= `GX_WORD_RST;
        tx_mem[i] <= `GX_WORD_RST;
      end
    end else begin
      if (ptn_wr) begin
        rx_mem[I_PTN_WR_IDX] <= I_PTN_WR_DATA;
      end
      if (master_wr) begin
        tx_mem[wr_idx] <= wr_val;
      end
    end
  end
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_RSP_VALID <= 1'b0;
      O_RSP_EXC <= `GX_EXC_NONE;
      O_RSP_STD <= 1'b0;
      O_RSP_DATA <= 16'h0000;
      O_PTN_RD_DATA <= `GX_WORD_RST;
      O_EFF_WORDS <= 8'h00;
    end else begin
      O_RSP_VALID <= I_REQ_VALID;
      O_RSP_EXC <= I_REQ_VALID ? next_exc : `GX_EXC_NONE;
      O_RSP_STD <= I_REQ_VALID && next_std;
      O_RSP_DATA <= I_REQ_VALID ? next_data : 16'h0000;
      O_PTN_RD_DATA <= ptn_rd;
      O_EFF_WORDS <= next_eff;
    end
  end

  // Checks.
  wire req_rd = I_REQ_VALID && !I_REQ_OBJ &&
                (I_REQ_FUNC == `GX_FC_RD_HOLD);
  wire req_wr = I_REQ_VALID && !I_REQ_OBJ &&
                (I_REQ_FUNC == `GX_FC_WR_REG);
  wire req_known = (I_REQ_FUNC == `GX_FC_RD_COILS) ||
                   (I_REQ_FUNC == `GX_FC_RD_DINS) ||
                   (I_REQ_FUNC == `GX_FC_RD_HOLD) ||
                   (I_REQ_FUNC == `GX_FC_RD_INPUT) ||
                   (I_REQ_FUNC == `GX_FC_WR_COIL) ||
                   (I_REQ_FUNC == `GX_FC_WR_REG) ||
                   (I_REQ_FUNC == `GX_FC_WR_COILS) ||
                   (I_REQ_FUNC == `GX_FC_WR_REGS) ||
                   (I_REQ_FUNC == `GX_FC_MASK_WR) ||
                   (I_REQ_FUNC == `GX_FC_RDWR);
  wire [15:0] arx_off = I_REQ_ADDR - `GX_ARX_BASE;
  wire [15:0] atx_off = I_REQ_ADDR - `GX_ATX_BASE;
  wire in_arx = arx_off < {8'h00, O_EFF_WORDS};
  wire in_atx = atx_off < {8'h00, O_EFF_WORDS};

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  a_known_func: assert property (
    I_REQ_VALID && !I_REQ_OBJ && req_known |=> O_RSP_EXC != `GX_EXC_FUNC)
    else $error("Supported function code answered as unknown.");
  a_rx_no_write: assert property (
    req_wr && (wloc.rgn == GX_RGN_RX) |=> O_RSP_EXC == `GX_EXC_ADDR)
    else $error("Write to partner receive word was not refused.");
  a_tx_write_lands: assert property (
    req_wr && (wloc.rgn == GX_RGN_TX)
    |=> tx_mem[$past(wloc.idx)] == $past(I_REQ_WDATA))
    else $error("Written word not found in the transmit cell.");
  a_alias_same_cell: assert property (
    req_wr && in_atx |=> tx_mem[$past(atx_off[7:0])] == $past(I_REQ_WDATA))
    else $error("Alias write missed the main cell.");
  a_alias_read_cell: assert property (
    req_rd && in_arx && !ptn_wr |=> O_RSP_DATA == rx_mem[$past(arx_off[7:0])])
    else $error("Alias read differs from the main cell.");
  a_link_state_read: assert property (
    req_rd && (I_REQ_ADDR == `GX_LINK_ADDR)
    |=> O_RSP_DATA == $past(link_q) && O_RSP_EXC == `GX_EXC_NONE)
    else $error("Link status word read back wrong.");
  a_bus_state_read: assert property (
    req_rd && (I_REQ_ADDR == `GX_BUS_ADDR) |=> O_RSP_DATA == $past(bus_q))
    else $error("Fieldbus status word read back wrong.");
  a_coil_bit_map: assert property (
    I_REQ_VALID && !I_REQ_OBJ && (I_REQ_FUNC == `GX_FC_RD_COILS) &&
    (cloc.rgn == GX_RGN_TX) && !master_wr
    |=> O_RSP_DATA[0] == tx_mem[$past(cloc.idx)][$past(cloc.bit_no)])
    else $error("Coil read does not match its word bit.");
  a_rx_coil_locked: assert property (
    I_REQ_VALID && !I_REQ_OBJ && (I_REQ_FUNC == `GX_FC_WR_COIL) &&
    (cloc.rgn == GX_RGN_RX) |-> !master_wr ##1 O_RSP_EXC == `GX_EXC_ADDR)
    else $error("Write to read-only coil was not refused.");
  a_obj_write_copy: assert property (
    I_REQ_VALID && I_REQ_OBJ && (I_REQ_FUNC == `GX_OBJ_OUT_DATA) && obj_hit
    |=> tx_mem[$past(obj_idx)] == $past(I_REQ_WDATA))
    else $error("Output object write did not reach the cell.");
  a_eff_limit: assert property (
    O_EFF_WORDS <= `GX_MAX_WORDS)
    else $error("Effective length exceeds the maximum.");
  a_unmapped_refused: assert property (
    req_rd && (wloc.rgn == GX_RGN_NONE)
    |=> O_RSP_EXC == `GX_EXC_ADDR && O_RSP_DATA == 16'h0000)
    else $error("Unmapped read not answered with an exception.");

  c_tx_write: cover property (req_wr && (wloc.rgn == GX_RGN_TX));
  c_coil_write: cover property (master_wr && (cloc.rgn == GX_RGN_TX));
  c_std_obj: cover property (I_REQ_VALID && I_REQ_OBJ && is_std_obj);
  c_bad_func: cover property (O_RSP_EXC == `GX_EXC_FUNC);

endmodule : gx_exchange_map

// >>> verification/gx_partner_model.sv
// Model of the partner gateway half that fills and drains the exchange.
`timescale 1ns/1ps
module gx_partner_model (
  // Clock
  input wire logic i_clk,
  // Receive area writes
  output logic o_wr_en,
  output logic [7:0] o_wr_idx,
  output logic [15:0] o_wr_data,
  // Transmit area reads
  output logic [7:0] o_rd_idx,
  input wire logic [15:0] i_rd_data
);
  initial begin
    o_wr_en = 1'b0;
    o_wr_idx = 8'h00;
    o_wr_data = 16'h0000;
    o_rd_idx = 8'h00;
  end

  // After a word is written the lines show its inverse, never a stale copy.
  task automatic put(input logic [7:0] idx, input logic [15:0] d);
    @(posedge i_clk);
    o_wr_en <= 1'b1;
    o_wr_idx <= idx;
    o_wr_data <= d;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_wr_idx <= ~idx;
    o_wr_data <= ~d;
  endtask : put

  // Read data follows the index by one cycle.
  task automatic get(input logic [7:0] idx, output logic [15:0] d);
    @(posedge i_clk);
    o_rd_idx <= idx;
    @(posedge i_clk);
    #1;
    d = i_rd_data;
  endtask : get
endmodule : gx_partner_model

// >>> verification/test_gateway_exchange_map.sv
// Self-checking bench of the gateway exchange map.
`timescale 1ns/1ps
`include "gx_consts.svh"
module test_gateway_exchange_map import gx_pkg::*; ;
  logic clk, rst, rv, ro, sv, ss, pwe;
  logic [7:0] rf, se, pwi, pri, ew, rexc;
  logic [15:0] ra, rr, rw, am, om, sd, pwd, prd, ls, bs, rdat, pd;
  logic [15:0] nr, nam, nom;
  logic [8:0] mb;
  logic rstd;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;

  gx_exchange_map DUT (
    .I_CORE_CLK(clk), .I_RST(rst), .I_REQ_VALID(rv), .I_REQ_OBJ(ro),
    .I_REQ_FUNC(rf), .I_REQ_ADDR(ra), .I_REQ_RD_ADDR(rr),
    .I_REQ_WDATA(rw), .I_REQ_AND_MASK(am), .I_REQ_OR_MASK(om),
    .O_RSP_VALID(sv), .O_RSP_EXC(se), .O_RSP_STD(ss), .O_RSP_DATA(sd),
    .I_PTN_WR_EN(pwe), .I_PTN_WR_IDX(pwi), .I_PTN_WR_DATA(pwd),
    .I_PTN_RD_IDX(pri), .O_PTN_RD_DATA(prd), .I_PTN_MAX_BYTES(mb),
    .I_LINK_STATE(ls), .I_BUS_STATE(bs), .O_EFF_WORDS(ew)
  );

  gx_partner_model ptn (
    .i_clk(clk), .o_wr_en(pwe), .o_wr_idx(pwi), .o_wr_data(pwd),
    .o_rd_idx(pri), .i_rd_data(prd)
  );

  always #4 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One request held for one edge; the answer is taken one cycle later.
  task automatic req(input logic o, input logic [7:0] f,
                     input logic [15:0] a, input logic [15:0] w);
    @(posedge clk);
    rv <= 1'b1;
    ro <= o;
    rf <= f;
    ra <= a;
    rw <= w;
    rr <= nr;
    am <= nam;
    om <= nom;
    @(posedge clk);
    rv <= 1'b0;
    ra <= ~a;
    rw <= ~w;
    #1;
    chk({15'h0000, sv}, 16'h0001);
    rexc = se;
    rdat = sd;
    rstd = ss;
  endtask : req

  task automatic t_tx();
    req(1'b0, 8'h03, 16'h0401, 16'h0000);
    chk(rdat, `GX_WORD_RST);
    req(1'b0, 8'h06, 16'h0401, 16'h1234);
    chk({8'h00, rexc}, 16'h0000);
    req(1'b0, 8'h03, 16'h9C41, 16'h0000);
    chk(rdat, 16'h1234);
    req(1'b0, 8'h04, 16'h0401, 16'h0000);
    chk(rdat, 16'h1234);
    ptn.get(8'h00, pd);
    chk(pd, 16'h1234);
    req(1'b0, 8'h06, 16'h9C42, 16'h4321);
    req(1'b0, 8'h03, 16'h0402, 16'h0000);
    chk(rdat, 16'h4321);
  endtask : t_tx

  task automatic t_rx();
    ptn.put(8'h05, 16'hBEEF);
    req(1'b0, 8'h03, 16'h0006, 16'h0000);
    chk(rdat, 16'hBEEF);
    req(1'b0, 8'h03, 16'h7536, 16'h0000);
    chk(rdat, 16'hBEEF);
    req(1'b0, 8'h06, 16'h0006, 16'h0000);
    chk({8'h00, rexc}, 16'h0002);
    req(1'b0, 8'h06, 16'h7536, 16'h0000);
    chk({8'h00, rexc}, 16'h0002);
    req(1'b0, 8'h03, 16'h0006, 16'h0000);
    chk(rdat, 16'hBEEF);
    req(1'b1, 8'hA0, 16'h0005, 16'h0000);
    chk(rdat, 16'hBEEF);
  endtask : t_rx

  task automatic t_coil();
    req(1'b0, 8'h10, 16'h0402, 16'h00F0);
    req(1'b0, 8'h05, 16'h4014, 16'h0001);
    chk({8'h00, rexc}, 16'h0000);
    req(1'b0, 8'h03, 16'h0402, 16'h0000);
    chk(rdat, 16'h00F8);
    req(1'b0, 8'h0F, 16'h4015, 16'h0000);
    req(1'b0, 8'h03, 16'h0402, 16'h0000);
    chk(rdat, 16'h00E8);
    req(1'b0, 8'h01, 16'h4014, 16'h0000);
    chk(rdat, 16'h0001);
    ptn.put(8'h01, 16'h8000);
    req(1'b0, 8'h02, 16'h0020, 16'h0000);
    chk(rdat, 16'h0001);
    req(1'b0, 8'h05, 16'h0020, 16'h0000);
    chk({8'h00, rexc}, 16'h0002);
    req(1'b0, 8'h01, 16'h0020, 16'h0000);
    chk(rdat, 16'h0001);
    req(1'b0, 8'h01, 16'h001F, 16'h0000);
    chk(rdat, 16'h0000);
  endtask : t_coil

  task automatic t_mask();
    nam = 16'hFF00;
    nom = 16'h00AB;
    req(1'b0, 8'h16, 16'h0401, 16'h0000);
    chk(rdat, 16'h12AB);
    req(1'b0, 8'h03, 16'h0401, 16'h0000);
    chk(rdat, 16'h12AB);
    nr = 16'h0403;
    req(1'b0, 8'h17, 16'h0403, 16'h5A5A);
    chk(rdat, 16'h5A5A);
    ptn.get(8'h02, pd);
    chk(pd, 16'h5A5A);
    nr = 16'h0006;
    req(1'b0, 8'h17, 16'h0404, 16'h6C6C);
    chk(rdat, 16'hBEEF);
    ptn.get(8'h03, pd);
    chk(pd, 16'h6C6C);
  endtask : t_mask

  // Status pins pass a synchroniser, so each code is given time to settle.
  task automatic t_stat();
    for (int i = 1; i <= 4; i++) begin
      @(posedge clk);
      ls <= 16'(i);
      repeat (8) @(posedge clk);
      req(1'b0, 8'h03, 16'h1001, 16'h0000);
      chk(rdat, 16'(i));
    end
    for (int i = 0; i <= 3; i++) begin
      @(posedge clk);
      bs <= 16'(i);
      repeat (8) @(posedge clk);
      req(1'b0, i[0] ? 8'h04 : 8'h03, 16'h1002, 16'h0000);
      chk(rdat, 16'(i));
    end
    req(1'b0, 8'h06, 16'h1002, 16'h0000);
    chk({8'h00, rexc}, 16'h0002);
  endtask : t_stat

  task automatic t_obj();
    logic [7:0] cls [8];
    cls = '{8'h01, 8'h02, 8'h04, 8'h06, 8'hF5, 8'hF6, 8'h47, 8'h48};
    foreach (cls[k]) begin
      req(1'b1, cls[k], 16'h0000, 16'h0000);
      chk({15'h0000, rstd}, 16'h0001);
      chk({8'h00, rexc}, 16'h0000);
    end
    req(1'b1, 8'hA1, 16'h0003, 16'hC3C3);
    chk({8'h00, rexc}, 16'h0000);
    ptn.get(8'h03, pd);
    chk(pd, 16'hC3C3);
    req(1'b1, 8'h33, 16'h0000, 16'h0000);
    chk({8'h00, rexc}, 16'h0001);
    chk({15'h0000, rstd}, 16'h0000);
    req(1'b1, 8'hA1, 16'h00F0, 16'hFFFF);
    chk({8'h00, rexc}, 16'h0002);
    req(1'b0, 8'h07, 16'h0401, 16'h0000);
    chk({8'h00, rexc}, 16'h0001);
    req(1'b0, 8'h06, 16'h0200, 16'hFFFF);
    chk({8'h00, rexc}, 16'h0002);
    req(1'b0, 8'h03, 16'h0200, 16'h0000);
    chk(rdat, 16'h0000);
  endtask : t_obj

  task automatic t_lim();
    @(posedge clk);
    mb <= 9'h0F4;
    repeat (2) @(posedge clk);
    #1;
    chk({8'h00, ew}, 16'h007A);
    chk({15'h0000, sv}, 16'h0000);
    req(1'b0, 8'h03, 16'h047A, 16'h0000);
    chk({8'h00, rexc}, 16'h0000);
    req(1'b0, 8'h03, 16'h047B, 16'h0000);
    chk({8'h00, rexc}, 16'h0002);
    @(posedge clk);
    mb <= 9'h1F4;
    repeat (2) @(posedge clk);
    #1;
    chk({8'h00, ew}, 16'h00F0);
    req(1'b0, 8'h03, 16'h04F0, 16'h0000);
    chk({8'h00, rexc}, 16'h0000);
    req(1'b0, 8'h03, 16'h04F1, 16'h0000);
    chk({8'h00, rexc}, 16'h0002);
    @(posedge clk);
    mb <= 9'h1E0;
  endtask : t_lim

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    rv = 1'b0;
    ro = 1'b0;
    rf = 8'h00;
    ra = 16'h0000;
    rr = 16'h0000;
    rw = 16'h0000;
    am = 16'h0000;
    om = 16'h0000;
    nr = 16'h0000;
    nam = 16'h0000;
    nom = 16'h0000;
    mb = 9'h1E0;
    ls = 16'h0000;
    bs = 16'h0000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_tx();
    t_rx();
    t_coil();
    t_mask();
    t_stat();
    t_obj();
    t_lim();
    finish_test();
  end
endmodule : test_gateway_exchange_map
